/* File: design/alci_map.svh */
// register offsets, field positions, reset values and timing figures of the alarm logic block
`ifndef ALCI_MAP_SVH
`define ALCI_MAP_SVH
`define ALCI_REG_BASIC_SEL 8'h00
`define ALCI_REG_BASIC_SEL_LAST 8'h1c
`define ALCI_REG_BASIC_CFG 8'h20
`define ALCI_REG_BASIC_CFG_LAST 8'h3c
`define ALCI_REG_ADV_CFG 8'h40
`define ALCI_REG_ADV_CFG_LAST 8'h4c
`define ALCI_REG_CTRL 8'h50
`define ALCI_REG_INHIBIT 8'h54
`define ALCI_REG_COEF 8'h58
`define ALCI_REG_COEF_LAST 8'h7c
`define ALCI_REG_RANGE 8'h80
`define ALCI_REG_RANGE_LAST 8'ha4
`define ALCI_REG_SPEED 8'ha8
`define ALCI_REG_STATUS 8'hac
`define ALCI_REG_HOST_ALARM 8'hb0
`define ALCI_REG_FUNC_OUT 8'hb4
`define ALCI_REG_CHAN_FLAG 8'hb8
`define ALCI_REG_LEVEL_IN 8'hbc
`define ALCI_REG_LEVEL_OUT 8'hc0
`define ALCI_CTRL_ADAPT 0
`define ALCI_CTRL_LSW_EN 1
`define ALCI_CTRL_LATCH_EN 2
`define ALCI_CTRL_LATCH_RST 3
`define ALCI_CTRL_CFG_LOAD 4
`define ALCI_CTRL_LSW_COEF_LSB 8
`define ALCI_CTRL_LSW_COEF_MSB 13
`define ALCI_CTRL_LOW_MODE 16
`define ALCI_COEF_UNITY 6'h0a
`define ALCI_COEF_MIN 6'h01
`define ALCI_COEF_MAX 6'h32
`define ALCI_STAB_MS 2000
`define ALCI_RECOV_MS 10000
`define ALCI_BLINK_MS 500
`define ALCI_CLK_KHZ 25000
`define ALCI_OPER_AND 2'h0
`define ALCI_OPER_OR 2'h1
`define ALCI_OPER_VOTE 2'h2
`endif

/* File: design/alci_pkg.sv */
// types shared by the alarm logic block
package alci_pkg;
    // per-channel flag set of a measurement or speed channel
    typedef struct packed {
        logic fault;
        logic sensor_ok;
        logic alert_hi;
        logic alert_lo;
        logic danger_hi;
        logic danger_lo;
        logic sensor_bypassed;
        logic invalid_out;
    } alci_flags_type;
    typedef enum logic [2:0] {
        ALCI_RUN = 3'b001,
        ALCI_INH = 3'b010,
        ALCI_REC = 3'b100
    } alci_inh_state_type;
endpackage

/* File: design/alci_top.sv */
// alarm combination, level scaling, danger suppression and channel inhibit with apb registers
`timescale 1ns/1ps
`include "alci_map.svh"

module alci_top
    import alci_pkg::*;
#(
    parameter int STAB_CYC = `ALCI_STAB_MS * `ALCI_CLK_KHZ,
    parameter int RECOV_CYC = `ALCI_RECOV_MS * `ALCI_CLK_KHZ,
    parameter int BLINK_CYC = `ALCI_BLINK_MS * `ALCI_CLK_KHZ,
    parameter int NBASIC = 8,
    parameter int NADV = 4,
    parameter int NRANGE = 10
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire alci_flags_type [3:0] MEAS_FLAGS,
    input wire alci_flags_type [1:0] DUAL_FLAGS,
    input wire alci_flags_type [1:0] SPEED_FLAGS,
    input wire logic [1:0] SPEED_REMOTE,
    input wire logic [2:0] COMMON_ALARM,
    input wire logic [7:0] HW_ERROR,
    input wire logic LEVEL_SWITCH_INPUT_N,
    input wire logic DANGER_SUPPRESS_INPUT_N,
    input wire logic [5:0] CHAN_SUPPLY_EN,
    output logic [NBASIC-1:0] BASIC_OUT,
    output logic [NADV-1:0] ADV_OUT,
    output logic [5:0] COEF_OUT,
    output alci_flags_type [5:0] CHAN_FLAGS_OUT,
    output logic [5:0] LED_GREEN_BLINK,
    output logic [5:0] SUPPLY_DC_EN,
    output logic [5:0] INHIBIT_ACTIVE,
    output logic [1:0] SPEED_FORWARD,
    output logic [15:0] LEVEL_OUT
);
    // ----------------------------------------------------------------
    // operand vector: 64 alarm bits
    // ----------------------------------------------------------------
    localparam int NOP = 64;
    logic [31:0] basic_sel_lo_r [NBASIC];
    logic [31:0] basic_sel_hi_r [NBASIC];
    logic [31:0] basic_cfg_r [NBASIC];
    logic [NBASIC-1:0] adv_sel_r [NADV];
    logic adv_or_r [NADV];
    logic [31:0] ctrl_r;
    logic [5:0] inhibit_req_r;
    logic [5:0] coef_r [NRANGE];
    logic [15:0] range_r [NRANGE];
    logic [15:0] speed_r;
    logic [15:0] level_in_r;
    logic [1:0] lsw_sync_r;
    logic [1:0] dsup_sync_r;
    alci_inh_state_type inh_state_r [6];
    logic [31:0] inh_cnt_r [6];
    logic [5:0] inh_eff;
    logic [5:0] inh_flag;
    logic [5:0] release_pulse;
    logic [31:0] blink_cnt_r;
    logic blink_r;
    logic [31:0] latch_r;
    logic [31:0] raw_alarm;
    logic [31:0] live_alarm;
    logic [31:0] alarm_now;
    logic [NOP-1:0] operand;
    logic [NBASIC-1:0] basic_nxt;
    logic [NADV-1:0] adv_nxt;
    logic [5:0] coef_sel;
    logic [5:0] coef_nxt;
    alci_flags_type [5:0] flags_nxt;
    logic suppress;
    logic level_sw;
    logic apb_wr;
    logic apb_rd;

    assign apb_wr = PSEL & PENABLE & PWRITE;
    assign apb_rd = PSEL & ~PENABLE & ~PWRITE;

    // ----------------------------------------------------------------
    // external input synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            lsw_sync_r <= 2'h3;
            dsup_sync_r <= 2'h3;
        end else begin
            lsw_sync_r <= {lsw_sync_r[0], LEVEL_SWITCH_INPUT_N};
            dsup_sync_r <= {dsup_sync_r[0], DANGER_SUPPRESS_INPUT_N};
        end
    end
    // floating input pulls high: unity coefficient outside adaptive mode and no suppression
    assign level_sw = ~lsw_sync_r[1] & ctrl_r[`ALCI_CTRL_LSW_EN];
    assign suppress = ~dsup_sync_r[1];

    // ----------------------------------------------------------------
    // inhibit sequencer, one per channel (0-3 measure, 4-5 speed)
    // ----------------------------------------------------------------
    always_comb begin
        inh_eff = inhibit_req_r;
        // remote speed signals may not be inhibited
        inh_eff[4] = inhibit_req_r[4] & ~SPEED_REMOTE[0];
        inh_eff[5] = inhibit_req_r[5] & ~SPEED_REMOTE[1];
        // measurement channels depend on speed 0 for tracking
        for (int i = 0; i < 4; i++) begin
            inh_eff[i] = inh_eff[i] | inh_eff[4];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_inh
            always_ff @(posedge CLOCK) begin
                if (!RST_N) begin
                    inh_state_r[g] <= ALCI_RUN;
                    inh_cnt_r[g] <= 32'h0;
                end else begin
                    case (inh_state_r[g])
                        ALCI_RUN: begin
                            if (inh_eff[g]) begin
                                inh_state_r[g] <= ALCI_INH;
                            end
                        end
                        ALCI_INH: begin
                            if (!inh_eff[g]) begin
                                inh_state_r[g] <= ALCI_REC;
                                inh_cnt_r[g] <= 32'(STAB_CYC + RECOV_CYC - 1);
                            end
                        end
                        ALCI_REC: begin
                            if (inh_eff[g]) begin
                                inh_state_r[g] <= ALCI_INH;
                            end else if (inh_cnt_r[g] == 32'h0) begin
                                inh_state_r[g] <= ALCI_RUN;
                            end else begin
                                inh_cnt_r[g] <= inh_cnt_r[g] - 32'h1;
                            end
                        end
                        default: inh_state_r[g] <= ALCI_RUN;
                    endcase
                end
            end
            assign inh_flag[g] = (inh_state_r[g] != ALCI_RUN);
            assign release_pulse[g] = (inh_state_r[g] == ALCI_REC) && !inh_eff[g]
                && (inh_cnt_r[g] == 32'h0);
        end
    endgenerate

    // ----------------------------------------------------------------
    // channel flags: forced while inhibited, suppression of danger
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            flags_nxt[i] = (i < 4) ? MEAS_FLAGS[i] : SPEED_FLAGS[i-4];
            if (i >= 4) begin
                flags_nxt[i].danger_hi = 1'b0;
                flags_nxt[i].danger_lo = 1'b0;
            end
            if (inh_flag[i]) begin
                flags_nxt[i].fault = 1'b0;
                flags_nxt[i].sensor_ok = 1'b1;
                flags_nxt[i].alert_hi = 1'b0;
                flags_nxt[i].alert_lo = 1'b0;
                flags_nxt[i].danger_hi = 1'b0;
                flags_nxt[i].danger_lo = 1'b0;
                flags_nxt[i].sensor_bypassed = 1'b1;
                flags_nxt[i].invalid_out = 1'b1;
            end else begin
                flags_nxt[i].sensor_bypassed = 1'b0;
            end
        end
    end

    // raw alarms keep the danger bits for host reporting
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            raw_alarm[4*i +: 4] = {flags_nxt[i].alert_hi, flags_nxt[i].alert_lo,
                flags_nxt[i].danger_hi, flags_nxt[i].danger_lo};
        end
        for (int i = 0; i < 2; i++) begin
            raw_alarm[16+4*i +: 4] = {DUAL_FLAGS[i].alert_hi, DUAL_FLAGS[i].alert_lo,
                DUAL_FLAGS[i].danger_hi & ~inh_flag[2*i] & ~inh_flag[2*i+1],
                DUAL_FLAGS[i].danger_lo & ~inh_flag[2*i] & ~inh_flag[2*i+1]};
            raw_alarm[24+2*i +: 2] = {flags_nxt[4+i].alert_hi, flags_nxt[4+i].alert_lo};
        end
        raw_alarm[31:28] = 4'h0;
        live_alarm = raw_alarm;
        for (int i = 0; i < 6; i++) begin
            live_alarm[4*i+1] = raw_alarm[4*i+1] & ~suppress;
            live_alarm[4*i] = raw_alarm[4*i] & ~suppress;
        end
    end

    // ----------------------------------------------------------------
    // optional alarm latch
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            latch_r <= 32'h0;
        end else begin
            // a new alarm wins over a simultaneous clear
            if (ctrl_r[`ALCI_CTRL_LATCH_EN]) begin
                latch_r <= latch_r | live_alarm;
            end else begin
                latch_r <= 32'h0;
            end
            for (int i = 0; i < 6; i++) begin
                if (release_pulse[i]) begin
                    latch_r[4*i +: 4] <= live_alarm[4*i +: 4];
                end
            end
            if (ctrl_r[`ALCI_CTRL_LATCH_RST]) begin
                latch_r <= live_alarm;
            end
        end
    end
    assign alarm_now = live_alarm | (ctrl_r[`ALCI_CTRL_LATCH_EN] ? latch_r : 32'h0);
    assign operand = {HW_ERROR, 15'h0, inh_flag, COMMON_ALARM, 32'(alarm_now)};

    // ----------------------------------------------------------------
    // basic and advanced logic functions
    // ----------------------------------------------------------------
    always_comb begin
        logic [NOP-1:0] sel;
        logic [6:0] cnt;
        sel = '0;
        cnt = 7'h0;
        for (int b = 0; b < NBASIC; b++) begin
            sel = {basic_sel_hi_r[b], basic_sel_lo_r[b]};
            cnt = 7'h0;
            for (int k = 0; k < NOP; k++) begin
                cnt = cnt + 7'(sel[k] & operand[k]);
            end
            case (basic_cfg_r[b][1:0])
                `ALCI_OPER_AND: basic_nxt[b] = (sel != '0) && ((sel & operand) == sel);
                `ALCI_OPER_OR: basic_nxt[b] = |(sel & operand);
                `ALCI_OPER_VOTE: basic_nxt[b] = cnt > basic_cfg_r[b][14:8];
                default: basic_nxt[b] = 1'b0;
            endcase
        end
        for (int a = 0; a < NADV; a++) begin
            if (adv_or_r[a]) begin
                adv_nxt[a] = |(adv_sel_r[a] & basic_nxt);
            end else begin
                adv_nxt[a] = (adv_sel_r[a] != '0) && ((adv_sel_r[a] & basic_nxt) == adv_sel_r[a]);
            end
        end
    end

    // ----------------------------------------------------------------
    // level coefficient selection and scaling
    // ----------------------------------------------------------------
    always_comb begin
        coef_sel = `ALCI_COEF_UNITY;
        for (int r = NRANGE - 1; r >= 0; r--) begin
            if (speed_r < range_r[r]) begin
                coef_sel = coef_r[r];
            end
        end
        if (ctrl_r[`ALCI_CTRL_ADAPT]) begin
            coef_nxt = coef_sel;
        end else if (level_sw) begin
            coef_nxt = ctrl_r[`ALCI_CTRL_LSW_COEF_MSB:`ALCI_CTRL_LSW_COEF_LSB];
        end else begin
            coef_nxt = `ALCI_COEF_UNITY;
        end
        if (coef_nxt < `ALCI_COEF_MIN || coef_nxt > `ALCI_COEF_MAX) begin
            coef_nxt = `ALCI_COEF_UNITY;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    logic signed [23:0] prod;
    assign prod = 24'($signed(level_in_r) * $signed({2'b00, coef_nxt}) / 10);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            BASIC_OUT <= '0;
            ADV_OUT <= '0;
            COEF_OUT <= `ALCI_COEF_UNITY;
            CHAN_FLAGS_OUT <= '0;
            INHIBIT_ACTIVE <= 6'h0;
            SUPPLY_DC_EN <= 6'h0;
            SPEED_FORWARD <= 2'h0;
            LEVEL_OUT <= 16'h0;
            LED_GREEN_BLINK <= 6'h0;
        end else begin
            // relay sources see suppressed, latched alarms beside common alarms, inhibit flags and hardware errors
            BASIC_OUT <= basic_nxt;
            ADV_OUT <= adv_nxt;
            COEF_OUT <= coef_nxt;
            CHAN_FLAGS_OUT <= flags_nxt;
            INHIBIT_ACTIVE <= inh_flag;
            SUPPLY_DC_EN <= CHAN_SUPPLY_EN;
            SPEED_FORWARD <= {SPEED_FLAGS[1].sensor_ok, SPEED_FLAGS[0].sensor_ok};
            LED_GREEN_BLINK <= inh_flag & {6{blink_r}};
            if (level_in_r[15] == 1'b0 && ctrl_r[`ALCI_CTRL_LOW_MODE]
                && coef_nxt != `ALCI_COEF_UNITY) begin
                LEVEL_OUT <= 16'h0;
            end else begin
                LEVEL_OUT <= prod[15:0];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
            blink_cnt_r <= 32'h0;
            blink_r <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // apb register file, zero wait state
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl_r <= 32'h0;
            inhibit_req_r <= 6'h0;
            speed_r <= 16'h0;
            level_in_r <= 16'h0;
            for (int i = 0; i < NBASIC; i++) begin
                basic_sel_lo_r[i] <= 32'h0;
                basic_sel_hi_r[i] <= 32'h0;
                basic_cfg_r[i] <= 32'h0;
            end
            for (int i = 0; i < NADV; i++) begin
                adv_sel_r[i] <= '0;
                adv_or_r[i] <= 1'b0;
            end
            for (int i = 0; i < NRANGE; i++) begin
                coef_r[i] <= `ALCI_COEF_UNITY;
                range_r[i] <= 16'hffff;
            end
        end else begin
            ctrl_r[`ALCI_CTRL_LATCH_RST] <= 1'b0;
            ctrl_r[`ALCI_CTRL_CFG_LOAD] <= 1'b0;
            if (ctrl_r[`ALCI_CTRL_CFG_LOAD]) begin
                inhibit_req_r <= 6'h0;
            end
            if (apb_wr) begin
                if (PADDR < `ALCI_REG_BASIC_CFG) begin
                    if (PADDR[2]) begin
                        basic_sel_hi_r[PADDR[4:3]] <= PWDATA;
                    end else begin
                        basic_sel_lo_r[PADDR[4:3]] <= PWDATA;
                    end
                end else if (PADDR <= `ALCI_REG_BASIC_CFG_LAST) begin
                    basic_cfg_r[3'(PADDR[4:2])] <= PWDATA;
                end else if (PADDR <= `ALCI_REG_ADV_CFG_LAST) begin
                    adv_sel_r[PADDR[3:2]] <= PWDATA[NBASIC-1:0];
                    adv_or_r[PADDR[3:2]] <= PWDATA[16];
                end else if (PADDR == `ALCI_REG_CTRL) begin
                    ctrl_r <= PWDATA;
                end else if (PADDR == `ALCI_REG_INHIBIT) begin
                    inhibit_req_r <= PWDATA[5:0];
                end else if (PADDR >= `ALCI_REG_COEF && PADDR <= `ALCI_REG_COEF_LAST) begin
                    coef_r[4'((PADDR - `ALCI_REG_COEF) >> 2)] <= PWDATA[5:0];
                end else if (PADDR >= `ALCI_REG_RANGE && PADDR <= `ALCI_REG_RANGE_LAST) begin
                    range_r[4'((PADDR - `ALCI_REG_RANGE) >> 2)] <= PWDATA[15:0];
                end else if (PADDR == `ALCI_REG_SPEED) begin
                    speed_r <= PWDATA[15:0];
                end else if (PADDR == `ALCI_REG_LEVEL_IN) begin
                    level_in_r <= PWDATA[15:0];
                end
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= 1'b0;
            if (apb_rd) begin
                if (PADDR == `ALCI_REG_CTRL) begin
                    PRDATA <= ctrl_r;
                end else if (PADDR == `ALCI_REG_INHIBIT) begin
                    PRDATA <= {26'h0, inhibit_req_r};
                end else if (PADDR == `ALCI_REG_STATUS) begin
                    PRDATA <= {16'h0, inh_flag, 2'h0, ~dsup_sync_r[1], ~lsw_sync_r[1], coef_nxt};
                end else if (PADDR == `ALCI_REG_HOST_ALARM) begin
                    PRDATA <= raw_alarm;
                end else if (PADDR == `ALCI_REG_FUNC_OUT) begin
                    PRDATA <= {20'h0, ADV_OUT, BASIC_OUT};
                end else if (PADDR == `ALCI_REG_CHAN_FLAG) begin
                    PRDATA <= {CHAN_FLAGS_OUT[3], CHAN_FLAGS_OUT[2],
                        CHAN_FLAGS_OUT[1], CHAN_FLAGS_OUT[0]};
                end else if (PADDR == `ALCI_REG_LEVEL_OUT) begin
                    PRDATA <= {16'h0, LEVEL_OUT};
                end else begin
                    PRDATA <= 32'h0;
                end
            end
        end
    end
endmodule // alci_top

/* File: verification/alci_contacts.sv */
// external control contacts for level switch and danger suppression
`timescale 1ns/1ps
module alci_contacts (
    input wire logic lsw_close,
    input wire logic dsup_close,
    output logic lsw_n,
    output logic dsup_n
);
    // an open contact floats, so the line sits at its pull-up
    assign lsw_n = lsw_close ? 1'b0 : 1'b1;
    assign dsup_n = dsup_close ? 1'b0 : 1'b1;
endmodule // alci_contacts

/* File: verification/alci_top_properties.sv */
// concurrent checks on the ports of the alarm logic block
`timescale 1ns/1ps
module alci_top_properties
    import alci_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire alci_flags_type [1:0] SPEED_FLAGS,
    input wire logic [5:0] CHAN_SUPPLY_EN,
    input wire logic [5:0] COEF_OUT,
    input wire alci_flags_type [5:0] CHAN_FLAGS_OUT,
    input wire logic [5:0] LED_GREEN_BLINK,
    input wire logic [5:0] SUPPLY_DC_EN,
    input wire logic [5:0] INHIBIT_ACTIVE,
    input wire logic [1:0] SPEED_FORWARD
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    ready_zero_wait_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing in access phase");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    no_slverr_a: assert property (PSLVERR == 1'b0)
        else $error("slave error raised");
    supply_kept_a: assert property ($past(RST_N) |-> SUPPLY_DC_EN == $past(CHAN_SUPPLY_EN))
        else $error("supply enable not passed through");
    speed_fwd_a: assert property ($past(RST_N) |-> SPEED_FORWARD ==
        {$past(SPEED_FLAGS[1].sensor_ok), $past(SPEED_FLAGS[0].sensor_ok)})
        else $error("speed not forwarded");
    meas_forced_a: assert property (INHIBIT_ACTIVE[0] && $past(INHIBIT_ACTIVE[0]) |->
        !CHAN_FLAGS_OUT[0].fault && !CHAN_FLAGS_OUT[0].alert_hi && CHAN_FLAGS_OUT[0].invalid_out)
        else $error("inhibited channel flags not forced");
    speed_forced_a: assert property (INHIBIT_ACTIVE[4] && $past(INHIBIT_ACTIVE[4]) |->
        !CHAN_FLAGS_OUT[4].alert_hi && CHAN_FLAGS_OUT[4].invalid_out)
        else $error("inhibited speed flags not forced");
    coef_range_a: assert property (COEF_OUT inside {[6'h01:6'h32]})
        else $error("coefficient out of range");
    blink_inhibit_a: assert property ($changed(LED_GREEN_BLINK[0]) |->
        INHIBIT_ACTIVE[0] || $past(INHIBIT_ACTIVE[0]))
        else $error("led blinks without inhibit");
    inh_start_c: cover property ($rose(INHIBIT_ACTIVE[4]));
    inh_end_c: cover property ($fell(INHIBIT_ACTIVE[0]));
    blink_c: cover property ($changed(LED_GREEN_BLINK[0]));
endmodule // alci_top_properties

bind alci_top alci_top_properties i_alci_top_properties (.CLOCK(CLOCK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SPEED_FLAGS(SPEED_FLAGS), .CHAN_SUPPLY_EN(CHAN_SUPPLY_EN), .COEF_OUT(COEF_OUT),
    .CHAN_FLAGS_OUT(CHAN_FLAGS_OUT), .LED_GREEN_BLINK(LED_GREEN_BLINK),
    .SUPPLY_DC_EN(SUPPLY_DC_EN), .INHIBIT_ACTIVE(INHIBIT_ACTIVE), .SPEED_FORWARD(SPEED_FORWARD));

/* File: verification/testbench.sv */
// self-checking testbench of the alarm logic block
`timescale 1ns/1ps
module testbench
    import alci_pkg::*;
;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, lsw_close, dsup_close;
    logic lsw_n, dsup_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    alci_flags_type [3:0] meas;
    alci_flags_type [1:0] speed, dual;
    alci_flags_type [5:0] flags;
    logic [7:0] basic_out;
    logic [3:0] adv_out;
    logic [5:0] coef_out, supply_en, inh;
    logic [1:0] remote;
    logic [15:0] level;
    int error_cnt, check_count, cycles;
    logic [7:0] cfg_a [14] = '{8'h00, 8'h20, 8'h08, 8'h24, 8'h10, 8'h28, 8'h18, 8'h1c,
        8'h40, 8'h44, 8'h58, 8'h80, 8'h5c, 8'h84};
    logic [31:0] cfg_d [14] = '{32'h88, 32'h1, 32'h20002, 32'h1, 32'h888, 32'h102, 32'h80,
        32'h8, 32'h3, 32'h10003, 32'h0c, 32'h64, 32'h32, 32'hc8};

    alci_top #(.STAB_CYC(8), .RECOV_CYC(8), .BLINK_CYC(4)) i_alci_top (.CLOCK(clock),
        .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MEAS_FLAGS(meas), .DUAL_FLAGS(dual), .SPEED_FLAGS(speed), .SPEED_REMOTE(remote),
        .COMMON_ALARM(3'h0), .HW_ERROR(8'h00), .LEVEL_SWITCH_INPUT_N(lsw_n),
        .DANGER_SUPPRESS_INPUT_N(dsup_n), .CHAN_SUPPLY_EN(supply_en), .BASIC_OUT(basic_out),
        .ADV_OUT(adv_out), .COEF_OUT(coef_out), .CHAN_FLAGS_OUT(flags), .LED_GREEN_BLINK(),
        .SUPPLY_DC_EN(), .INHIBIT_ACTIVE(inh), .SPEED_FORWARD(), .LEVEL_OUT(level));
    alci_contacts i_alci_contacts (.lsw_close(lsw_close), .dsup_close(dsup_close),
        .lsw_n(lsw_n), .dsup_n(dsup_n));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hung handshakes end here instead of stalling the run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            print_verdict;
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic s_logic;
        @(posedge clock) meas[0].alert_hi <= 1'b1;
        settle(4);
        chk("or_one", basic_out[0], 1'b1);
        chk("vote_one", basic_out[2], 1'b0);
        chk("adv_or", adv_out[1], 1'b1);
        chk("adv_and", adv_out[0], 1'b0);
        @(posedge clock) meas[1].alert_hi <= 1'b1;
        @(posedge clock) meas[0].danger_hi <= 1'b1;
        settle(4);
        chk("vote_two", basic_out[2], 1'b1);
        chk("danger_or", basic_out[1], 1'b1);
        chk("adv_and_two", adv_out[0], 1'b1);
        @(posedge clock) {dsup_close, dual[0].danger_hi} <= 2'b11;
        settle(5);
        chk("supp_basic", basic_out[1], 1'b0);
        chk("supp_adv", adv_out[0], 1'b0);
        apb(1'b0, 8'hb0, 32'h0);
        chk("host_danger", rd, 32'h2008a);
        @(posedge clock) dsup_close <= 1'b0;
        settle(5);
        chk("supp_off", basic_out[1], 1'b1);
        apb(1'b1, 8'h50, 32'h4);
        @(posedge clock) {meas[0].alert_hi, meas[1].alert_hi} <= 2'b00;
        settle(3);
        chk("latch_hold", basic_out[0], 1'b1);
        apb(1'b1, 8'h50, 32'hc);
        settle(3);
        chk("latch_clr", basic_out[0], 1'b0);
        @(posedge clock) {meas[0].alert_hi, meas[1].alert_hi} <= 2'b11;
    endtask

    task automatic s_coef;
        apb(1'b1, 8'ha8, 32'h32);
        apb(1'b1, 8'h50, 32'h1);
        settle(3);
        chk("adapt_low", coef_out, 6'h0c);
        apb(1'b1, 8'hbc, 32'hffce);
        settle(2);
        chk("level_neg", level, 16'hffc4);
        apb(1'b1, 8'h50, 32'h10001);
        apb(1'b1, 8'hbc, 32'h64);
        settle(2);
        chk("level_pos_off", level, 16'h0);
        apb(1'b1, 8'ha8, 32'h96);
        settle(3);
        chk("adapt_max", coef_out, 6'h32);
        apb(1'b1, 8'h50, 32'h1902);
        @(posedge clock) lsw_close <= 1'b1;
        settle(5);
        chk("coef_sw", coef_out, 6'h19);
        chk("level_up", level, 16'hfa);
        @(posedge clock) lsw_close <= 1'b0;
        settle(5);
        chk("coef_float", coef_out, 6'h0a);
        apb(1'b1, 8'h50, 32'h0);
    endtask

    task automatic s_inhibit;
        @(posedge clock) meas[0].fault <= 1'b1;
        apb(1'b1, 8'h54, 32'h1);
        settle(3);
        chk("inh_act", inh, 6'h01);
        chk("inh_sbp", flags[0].sensor_bypassed, 1'b1);
        chk("inh_fault", flags[0].fault, 1'b0);
        chk("inh_vote", basic_out[2], 1'b0);
        chk("inh_oper", basic_out[3], 1'b1);
        apb(1'b1, 8'h54, 32'h0);
        settle(17);
        chk("inh_recov", inh[0], 1'b1);
        settle(1);
        chk("inh_end", inh[0], 1'b0);
        chk("rel_sbp", flags[0].sensor_bypassed, 1'b0);
        chk("rel_alert", flags[0].alert_hi, 1'b1);
        @(posedge clock) remote <= 2'h1;
        apb(1'b1, 8'h54, 32'h10);
        settle(3);
        chk("remote_inh", inh, 6'h00);
        @(posedge clock) remote <= 2'h0;
        settle(3);
        chk("spd_inh", inh, 6'h1f);
        chk("spd_sbp", flags[4].sensor_bypassed, 1'b1);
        apb(1'b1, 8'h50, 32'h10);
        settle(3);
        apb(1'b0, 8'h54, 32'h0);
        chk("load_req", rd, 32'h0);
        settle(20);
        chk("load_cancel", inh, 6'h00);
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, lsw_close, dsup_close} = 6'h00;
        {paddr, pwdata, meas} = 72'h0;
        speed = 16'h4040;
        supply_en = 6'h2d;
        {dual, remote} = 18'h0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk("coef_rst", coef_out, 6'h0a);
        foreach (cfg_a[i]) apb(1'b1, cfg_a[i], cfg_d[i]);
        apb(1'b0, 8'hac, 32'h0);
        chk("status_rd", rd, 32'h0a);
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped", rd, 32'h0);
        s_logic;
        s_coef;
        s_inhibit;
        print_verdict;
    end
endmodule // testbench
